// ### src/icwt_channel.sv
// one capture channel: edge select, edge prescaler, four-word fifo
module icwt_channel import icwt_pkg::*; (
	input  wire logic              i_core_clk,
	input  wire logic              i_rst,
	input  wire logic              i_ce,
	input  wire logic              i_rise,
	input  wire logic              i_fall,
	input  wire logic [DATA_W-1:0] i_low_count,
	input  wire logic [DATA_W-1:0] i_high_count,
	input  wire logic              i_ctl_wr,
	input  wire logic [DATA_W-1:0] i_ctl_data,
	input  wire logic              i_pop,
	output logic      [DATA_W-1:0] o_head,
	output logic      [DATA_W-1:0] o_control,
	output logic                   o_event
);
	logic [DATA_W-1:0] fifo_reg [FIFO_DEPTH];
	logic [2:0]        count_reg;
	logic              ov_reg;
	logic              tsel_reg;
	icwt_mode_type     mode_reg;
	logic [3:0]        ps_reg;
	logic              hit;
	logic              store;
	logic              do_store;
	logic              ov_set;
	logic              pop;
	logic [2:0]        wr_pos;
	logic [DATA_W-1:0] stamp;

	always_comb begin
		hit = 1'b0;
		unique case (mode_reg)
			MODE_BOTH:            hit = i_rise | i_fall;
			MODE_FALL:            hit = i_fall;
			MODE_RISE, MODE_WAKE: hit = i_rise;
			MODE_RISE4:   hit = i_rise && ps_reg == PS_DIV4_LAST;
			MODE_RISE16:  hit = i_rise && ps_reg == PS_DIV16_LAST;
			MODE_OFF, MODE_RSVD:  hit = 1'b0;
		endcase
	end

	// after an overflow nothing is stored until the fifo drains
	assign store    = hit && mode_reg != MODE_WAKE && !ov_reg;
	assign pop      = i_pop && count_reg != 3'h0;
	assign ov_set   = store && count_reg == 3'(FIFO_DEPTH) && !pop;
	assign do_store = store && !ov_set;
	assign wr_pos   = pop ? count_reg - 3'h1 : count_reg;
	assign stamp    = tsel_reg ? i_low_count : i_high_count;
	assign o_event  = i_ce && hit;
	assign o_head   = fifo_reg[0];

	always_comb begin
		o_control = '0;
		o_control[ICON_TSEL_BIT] = tsel_reg;
		o_control[ICON_OV_BIT]   = ov_reg;
		o_control[ICON_NE_BIT]   = count_reg != 3'h0;
		o_control[ICON_MODE_HI:ICON_MODE_LO] = mode_reg;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			tsel_reg <= 1'b0;
			mode_reg <= MODE_OFF;
		end else if (i_ce && i_ctl_wr) begin
			tsel_reg <= i_ctl_data[ICON_TSEL_BIT];
			mode_reg <= icwt_mode_type'(i_ctl_data[ICON_MODE_HI:ICON_MODE_LO]);
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			ps_reg <= '0;
		end else if (i_ce) begin
			if (mode_reg == MODE_OFF)
				ps_reg <= '0;
			else if (i_rise && (mode_reg == MODE_RISE4 ||
					mode_reg == MODE_RISE16))
				ps_reg <= (mode_reg == MODE_RISE4 && ps_reg == PS_DIV4_LAST) ?
					4'h0 : ps_reg + 4'h1;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			count_reg <= '0;
			ov_reg    <= 1'b0;
		end else if (i_ce) begin
			count_reg <= count_reg + 3'(do_store) - 3'(pop);
			if (ov_set)
				ov_reg <= 1'b1;
			else if (count_reg == 3'h0)
				ov_reg <= 1'b0;
		end
	end

	// entries only shift, so no data reset is needed
	always_ff @(posedge i_core_clk) begin
		if (i_ce) begin
			if (pop)
				for (int i = 0; i < FIFO_DEPTH - 1; i++)
					fifo_reg[i] <= fifo_reg[i+1];
			if (do_store)
				fifo_reg[wr_pos[1:0]] <= stamp;
		end
	end

	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	a_overflow_flag_set: assert property (i_ce && ov_set |=> ov_reg)
		else $error("overflow flag not set on fifth capture");
	a_overflow_discard: assert property (i_ce && ov_set |=>
		count_reg == 3'(FIFO_DEPTH) && fifo_reg[3] == $past(fifo_reg[3]))
		else $error("fifth capture was stored");
	a_ignore_after_ov: assert property (i_ce && ov_reg |=>
		count_reg <= $past(count_reg))
		else $error("capture stored while overflowed");
	a_prescale_off_clr: assert property (i_ce &&
		mode_reg == MODE_OFF |=> ps_reg == 4'h0)
		else $error("prescaler not cleared when off");
	a_pop_shift_fwd: assert property (i_ce && pop &&
		count_reg > 3'h1 |=> o_head == $past(fifo_reg[1]))
		else $error("fifo did not advance on read");
	a_first_capture_ne: assert property (i_ce && do_store &&
		count_reg == 3'h0 |=> o_control[ICON_NE_BIT])
		else $error("not empty flag missing after capture");
	c_overflow: cover property (i_ce && ov_set);
	c_full_pop: cover property (i_ce && pop && count_reg == 3'(FIFO_DEPTH));
endmodule

// ### src/icwt_pkg.sv
// shared constants and types for the capture unit and its time base
package icwt_pkg;
	localparam int DATA_W     = 16;
	localparam int CH_NUM     = 8;
	localparam int FIFO_DEPTH = 4;
	localparam int ADDR_W     = 12;
	localparam int IDX_W      = 10;
	localparam int PIN_NUM    = 10;
	localparam int PIN_LOW    = 8;
	localparam int PIN_HIGH   = 9;

	// register indices, byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_TIMER_LOW_COUNT    = 10'h106;
	localparam logic [IDX_W-1:0] IDX_TIMER_HIGH_HOLDING = 10'h108;
	localparam logic [IDX_W-1:0] IDX_TIMER_HIGH_COUNT   = 10'h10A;
	localparam logic [IDX_W-1:0] IDX_PERIOD_LOW_WORD    = 10'h10C;
	localparam logic [IDX_W-1:0] IDX_PERIOD_HIGH_WORD   = 10'h10E;
	localparam logic [IDX_W-1:0] IDX_LOW_TIMER_CONTROL  = 10'h110;
	localparam logic [IDX_W-1:0] IDX_HIGH_TIMER_CONTROL = 10'h112;
	localparam logic [IDX_W-1:0] IDX_INT_FLAG_ZERO      = 10'h084;
	localparam logic [IDX_W-1:0] IDX_INT_ENABLE_ZERO    = 10'h094;
	localparam logic [IDX_W-1:0] IDX_CAPTURE_FIRST      = 10'h140;
	localparam logic [IDX_W-1:0] IDX_CAPTURE_LAST       = 10'h15F;
	localparam int CAP_CH_LSB  = 2;
	localparam int CAP_CON_BIT = 1;
	localparam int CAP_ODD_BIT = 0;

	// timer control fields
	localparam int TCON_ON_BIT   = 15;
	localparam int TCON_SIDL_BIT = 13;
	localparam int TCON_GATE_BIT = 6;
	localparam int TCON_PS_HI    = 5;
	localparam int TCON_PS_LO    = 4;
	localparam int TCON_WIDE_BIT = 3;
	localparam int TCON_CS_BIT   = 1;
	localparam logic [15:0] LOW_CON_WMASK  = 16'hA07A;
	localparam logic [15:0] HIGH_CON_WMASK = 16'hA072;
	localparam logic [15:0] CON_RESET      = 16'h0000;
	localparam logic [15:0] PERIOD_RESET   = 16'hFFFF;
	localparam logic [15:0] COUNT_RESET    = 16'h0000;
	localparam logic [7:0]  TPS_LAST_1     = 8'h00;
	localparam logic [7:0]  TPS_LAST_8     = 8'h07;
	localparam logic [7:0]  TPS_LAST_64    = 8'h3F;
	localparam logic [7:0]  TPS_LAST_256   = 8'hFF;

	// capture control fields
	localparam int ICON_TSEL_BIT = 7;
	localparam int ICON_OV_BIT   = 4;
	localparam int ICON_NE_BIT   = 3;
	localparam int ICON_MODE_HI  = 2;
	localparam int ICON_MODE_LO  = 0;
	localparam logic [3:0] PS_DIV4_LAST  = 4'h3;
	localparam logic [3:0] PS_DIV16_LAST = 4'hF;

	// interrupt flag and enable layout
	localparam int FLAG_PAIR_BIT = 7;
	localparam int FLAG_LOW_BIT  = 6;
	localparam int FLAG_CAP_LSB  = 8;
	localparam logic [15:0] FLAG_MASK = 16'hFFC0;

	typedef enum logic [2:0] {
		MODE_OFF    = 3'h0,
		MODE_BOTH   = 3'h1,
		MODE_FALL   = 3'h2,
		MODE_RISE   = 3'h3,
		MODE_RISE4  = 3'h4,
		MODE_RISE16 = 3'h5,
		MODE_RSVD   = 3'h6,
		MODE_WAKE   = 3'h7
	} icwt_mode_type;
endpackage

// ### src/icwt_top.sv
// capture unit with paired time base and apb register slave
//
// Overview of operation
// - timers stand still during sleep
// - pair flag on 32-bit match or gate fall
// - pair flag sticky, cleared by software write
// - pair irq only when its enable set
// - holding register used only in wide mode
// - eight independent capture channels
// - mode selects fall, rise, 4th, 16th, both
// - channel off clears edge prescaler
// - reset clears every edge prescaler
// - four-entry 16-bit fifo per channel
// - not-empty set on capture until drained
// - read returns oldest, rest move forward
// - fifth capture on full sets overflow
// - overflowing capture value is dropped
// - captures ignored until overflowed fifo drained
// - empty buffer read returns undefined data
// - channel picks low or high timer
// - select bit seven, high timer default
// - wide mode counts to period then wraps
// - low word read latches high word
// - hold then low write loads high word
//
// Implementation choice: the APB slave port.
module icwt_top import icwt_pkg::*; (
	input  wire logic              i_core_clk,
	input  wire logic              i_rst,
	input  wire logic              i_ce,
	input  wire logic              i_sleep,
	input  wire logic              i_idle,
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [ADDR_W-1:0] i_paddr,
	input  wire logic [31:0]       i_pwdata,
	input  wire logic [3:0]        i_pstrb,
	output logic      [31:0]       o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	input  wire logic [CH_NUM-1:0] i_capture_pin,
	input  wire logic              i_low_clk_pin,
	input  wire logic              i_high_clk_pin,
	output logic                   o_pair_irq,
	output logic                   o_low_irq,
	output logic      [CH_NUM-1:0] o_capture_irq
);
	function automatic logic [7:0] prescale_last(input logic [1:0] sel);
		unique case (sel)
			2'h0: prescale_last = TPS_LAST_1;
			2'h1: prescale_last = TPS_LAST_8;
			2'h2: prescale_last = TPS_LAST_64;
			2'h3: prescale_last = TPS_LAST_256;
		endcase
	endfunction

	function automatic logic [15:0] strobed(input logic [15:0] old,
			input logic [15:0] data, input logic [1:0] strb);
		strobed = {strb[1] ? data[15:8] : old[15:8],
			strb[0] ? data[7:0] : old[7:0]};
	endfunction

	logic [PIN_NUM-1:0] sync1_reg;
	logic [PIN_NUM-1:0] sync2_reg;
	logic [PIN_NUM-1:0] sync3_reg;
	logic [PIN_NUM-1:0] level_reg;
	logic [PIN_NUM-1:0] prev_reg;
	logic [PIN_NUM-1:0] rise;
	logic [PIN_NUM-1:0] fall;

	logic [15:0] lo_cnt_reg;
	logic [15:0] hi_cnt_reg;
	logic [15:0] hold_reg;
	logic [15:0] pr_lo_reg;
	logic [15:0] pr_hi_reg;
	logic [15:0] lo_con_reg;
	logic [15:0] hi_con_reg;
	logic [15:0] flag_reg;
	logic [15:0] enable_reg;
	logic [7:0]  lo_ps_reg;
	logic [7:0]  hi_ps_reg;
	logic        done_reg;
	logic [31:0] prdata_reg;

	logic [IDX_W-1:0]   idx;
	logic               access;
	logic               rd_first;
	logic               wr;
	logic [15:0]        wdata;
	logic               cap_sel;
	logic [2:0]         cap_ch;
	logic               cap_con;
	logic               mapped;
	logic [15:0]        rd_mux;
	logic               wr_lo_cnt;
	logic               wr_hi_cnt;
	logic               wr_flag;
	logic               wide;
	logic               lo_run;
	logic               hi_run;
	logic               lo_src;
	logic               hi_src;
	logic               lo_tick;
	logic               hi_tick;
	logic               match32;
	logic               lo_match;
	logic               hi_match;
	logic               lo_gate_fall;
	logic               hi_gate_fall;
	logic [15:0]        flag_set;
	logic [CH_NUM-1:0]  cap_event;
	logic [15:0]        cap_head [CH_NUM];
	logic [15:0]        cap_ctl [CH_NUM];

	// pins pass three flops; a level is accepted once the last two agree
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
			level_reg <= '0;
			prev_reg  <= '0;
		end else if (i_ce) begin
			sync1_reg <= {i_high_clk_pin, i_low_clk_pin, i_capture_pin};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			level_reg <= (sync2_reg & sync3_reg) |
				(level_reg & (sync2_reg ^ sync3_reg));
			prev_reg  <= level_reg;
		end
	end
	assign rise = level_reg & ~prev_reg;
	assign fall = ~level_reg & prev_reg;

	// apb decode; one wait state so read data come from a flop
	assign idx      = i_paddr[ADDR_W-1:2];
	assign access   = i_psel && i_penable;
	assign o_pready = done_reg && i_ce;
	assign rd_first = access && !done_reg && !i_pwrite && i_ce;
	assign cap_sel  = idx >= IDX_CAPTURE_FIRST && idx <= IDX_CAPTURE_LAST &&
		!idx[CAP_ODD_BIT];
	assign cap_ch   = idx[CAP_CH_LSB+2:CAP_CH_LSB];
	assign cap_con  = idx[CAP_CON_BIT];
	assign wdata    = i_pwdata[15:0];
	assign o_prdata = prdata_reg;

	always_comb begin
		mapped = 1'b1;
		rd_mux = '0;
		unique case (idx)
			IDX_TIMER_LOW_COUNT:    rd_mux = lo_cnt_reg;
			IDX_TIMER_HIGH_HOLDING: rd_mux = hold_reg;
			IDX_TIMER_HIGH_COUNT:   rd_mux = hi_cnt_reg;
			IDX_PERIOD_LOW_WORD:    rd_mux = pr_lo_reg;
			IDX_PERIOD_HIGH_WORD:   rd_mux = pr_hi_reg;
			IDX_LOW_TIMER_CONTROL:  rd_mux = lo_con_reg;
			IDX_HIGH_TIMER_CONTROL: rd_mux = hi_con_reg;
			IDX_INT_FLAG_ZERO:      rd_mux = flag_reg;
			IDX_INT_ENABLE_ZERO:    rd_mux = enable_reg;
			default: begin
				mapped = cap_sel;
				if (cap_sel)
					rd_mux = cap_con ? cap_ctl[cap_ch] : cap_head[cap_ch];
			end
		endcase
	end

	assign o_pslverr = access && !mapped;
	assign wr        = access && i_pwrite && o_pready && mapped;
	assign wr_lo_cnt = wr && idx == IDX_TIMER_LOW_COUNT;
	assign wr_hi_cnt = wr && idx == IDX_TIMER_HIGH_COUNT;
	assign wr_flag   = wr && idx == IDX_INT_FLAG_ZERO;

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			done_reg   <= 1'b0;
			prdata_reg <= '0;
		end else if (i_ce) begin
			done_reg <= access && !done_reg;
			if (rd_first)
				prdata_reg <= {16'h0000, rd_mux};
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			pr_lo_reg  <= PERIOD_RESET;
			pr_hi_reg  <= PERIOD_RESET;
			lo_con_reg <= CON_RESET;
			hi_con_reg <= CON_RESET;
			enable_reg <= '0;
		end else if (i_ce && wr) begin
			if (idx == IDX_PERIOD_LOW_WORD)
				pr_lo_reg <= strobed(pr_lo_reg, wdata, i_pstrb[1:0]);
			if (idx == IDX_PERIOD_HIGH_WORD)
				pr_hi_reg <= strobed(pr_hi_reg, wdata, i_pstrb[1:0]);
			if (idx == IDX_LOW_TIMER_CONTROL)
				lo_con_reg <= strobed(lo_con_reg, wdata, i_pstrb[1:0]) &
					LOW_CON_WMASK;
			if (idx == IDX_HIGH_TIMER_CONTROL)
				hi_con_reg <= strobed(hi_con_reg, wdata, i_pstrb[1:0]) &
					HIGH_CON_WMASK;
			if (idx == IDX_INT_ENABLE_ZERO)
				enable_reg <= strobed(enable_reg, wdata, i_pstrb[1:0]) &
					FLAG_MASK;
		end
	end

	// time base; in wide mode the high control is ignored
	assign wide   = lo_con_reg[TCON_WIDE_BIT];
	assign lo_run = lo_con_reg[TCON_ON_BIT] && !i_sleep &&
		!(i_idle && lo_con_reg[TCON_SIDL_BIT]);
	assign hi_run = !wide && hi_con_reg[TCON_ON_BIT] && !i_sleep &&
		!(i_idle && hi_con_reg[TCON_SIDL_BIT]);
	assign lo_src = lo_con_reg[TCON_CS_BIT] ? rise[PIN_LOW] :
		(!lo_con_reg[TCON_GATE_BIT] || level_reg[PIN_LOW]);
	assign hi_src = hi_con_reg[TCON_CS_BIT] ? rise[PIN_HIGH] :
		(!hi_con_reg[TCON_GATE_BIT] || level_reg[PIN_HIGH]);
	assign lo_tick = lo_run && lo_src &&
		lo_ps_reg == prescale_last(lo_con_reg[TCON_PS_HI:TCON_PS_LO]);
	assign hi_tick = hi_run && hi_src &&
		hi_ps_reg == prescale_last(hi_con_reg[TCON_PS_HI:TCON_PS_LO]);
	assign match32  = {hi_cnt_reg, lo_cnt_reg} == {pr_hi_reg, pr_lo_reg};
	assign lo_match = lo_cnt_reg == pr_lo_reg;
	assign hi_match = hi_cnt_reg == pr_hi_reg;
	assign lo_gate_fall = lo_con_reg[TCON_ON_BIT] &&
		!lo_con_reg[TCON_CS_BIT] && lo_con_reg[TCON_GATE_BIT] && fall[PIN_LOW];
	assign hi_gate_fall = hi_run && !hi_con_reg[TCON_CS_BIT] &&
		hi_con_reg[TCON_GATE_BIT] && fall[PIN_HIGH];

	// prescalers clear on a count write or when the timer is off
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			lo_ps_reg <= '0;
			hi_ps_reg <= '0;
		end else if (i_ce) begin
			if (wr_lo_cnt || wr_hi_cnt || !lo_con_reg[TCON_ON_BIT])
				lo_ps_reg <= '0;
			else if (lo_run && lo_src)
				lo_ps_reg <= lo_tick ? 8'h00 : lo_ps_reg + 8'h01;
			if (wr_lo_cnt || wr_hi_cnt || !hi_con_reg[TCON_ON_BIT])
				hi_ps_reg <= '0;
			else if (hi_run && hi_src)
				hi_ps_reg <= hi_tick ? 8'h00 : hi_ps_reg + 8'h01;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			lo_cnt_reg <= COUNT_RESET;
			hi_cnt_reg <= COUNT_RESET;
		end else if (i_ce) begin
			if (wr_lo_cnt) begin
				lo_cnt_reg <= strobed(lo_cnt_reg, wdata, i_pstrb[1:0]);
				if (wide)
					hi_cnt_reg <= hold_reg;
			end else if (wr_hi_cnt) begin
				hi_cnt_reg <= strobed(hi_cnt_reg, wdata, i_pstrb[1:0]);
			end else if (wide) begin
				if (lo_tick)
					{hi_cnt_reg, lo_cnt_reg} <= match32 ? 32'h0000_0000 :
						{hi_cnt_reg, lo_cnt_reg} + 32'h0000_0001;
			end else begin
				if (lo_tick)
					lo_cnt_reg <= lo_match ? 16'h0000 : lo_cnt_reg + 16'h0001;
				if (hi_tick)
					hi_cnt_reg <= hi_match ? 16'h0000 : hi_cnt_reg + 16'h0001;
			end
		end
	end

	// holding word only matters in wide mode
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			hold_reg <= '0;
		end else if (i_ce) begin
			if (wr && idx == IDX_TIMER_HIGH_HOLDING)
				hold_reg <= strobed(hold_reg, wdata, i_pstrb[1:0]);
			else if (rd_first && wide && idx == IDX_TIMER_LOW_COUNT)
				hold_reg <= hi_cnt_reg;
		end
	end

	// flags: hardware set wins over a software write in the same cycle
	always_comb begin
		flag_set = '0;
		flag_set[FLAG_PAIR_BIT] = wide ?
			(lo_tick && match32 && !wr_lo_cnt && !wr_hi_cnt) || lo_gate_fall :
			(hi_tick && hi_match && !wr_hi_cnt) || hi_gate_fall;
		flag_set[FLAG_LOW_BIT] = !wide &&
			((lo_tick && lo_match && !wr_lo_cnt) || lo_gate_fall);
		flag_set[FLAG_CAP_LSB +: CH_NUM] = cap_event;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst)
			flag_reg <= '0;
		else if (i_ce)
			flag_reg <= (wr_flag ? strobed(flag_reg, wdata, i_pstrb[1:0]) &
				FLAG_MASK : flag_reg) | flag_set;
	end

	assign o_pair_irq = flag_reg[FLAG_PAIR_BIT] &&
		enable_reg[FLAG_PAIR_BIT];
	assign o_low_irq  = flag_reg[FLAG_LOW_BIT] && enable_reg[FLAG_LOW_BIT];
	assign o_capture_irq = flag_reg[FLAG_CAP_LSB +: CH_NUM] &
		enable_reg[FLAG_CAP_LSB +: CH_NUM];

	for (genvar g = 0; g < CH_NUM; g++) begin : g_ch
		icwt_channel u_ch (
			.i_core_clk   (i_core_clk),
			.i_rst        (i_rst),
			.i_ce         (i_ce),
			.i_rise       (rise[g]),
			.i_fall       (fall[g]),
			.i_low_count  (lo_cnt_reg),
			.i_high_count (hi_cnt_reg),
			.i_ctl_wr     (wr && cap_sel && cap_con && cap_ch == 3'(g)),
			.i_ctl_data   (strobed(cap_ctl[g], wdata, i_pstrb[1:0])),
			.i_pop        (rd_first && cap_sel && !cap_con &&
				cap_ch == 3'(g)),
			.o_head       (cap_head[g]),
			.o_control    (cap_ctl[g]),
			.o_event      (cap_event[g])
		);
	end

	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	a_sleep_freeze: assert property (i_ce && i_sleep && !wr |=>
		lo_cnt_reg == $past(lo_cnt_reg) && hi_cnt_reg == $past(hi_cnt_reg))
		else $error("timer counted during sleep");
	a_wide_wrap_flag: assert property (i_ce && wide && lo_tick &&
		match32 && !wr |=> lo_cnt_reg == 16'h0000 &&
		hi_cnt_reg == 16'h0000 && flag_reg[FLAG_PAIR_BIT])
		else $error("wide match did not wrap and flag");
	a_flag_sticky: assert property (flag_reg[FLAG_PAIR_BIT] &&
		!wr_flag |=> flag_reg[FLAG_PAIR_BIT])
		else $error("pair flag cleared without a write");
	a_hold_latch: assert property (rd_first && wide &&
		idx == IDX_TIMER_LOW_COUNT |=> hold_reg == $past(hi_cnt_reg))
		else $error("high word not latched on low read");
	a_coherent_write: assert property (wr_lo_cnt && wide |=>
		hi_cnt_reg == $past(hold_reg))
		else $error("held word not moved into high count");
	a_irq_needs_enable: assert property (
		!enable_reg[FLAG_PAIR_BIT] |-> !o_pair_irq ##1
		(!enable_reg[FLAG_PAIR_BIT] -> !o_pair_irq))
		else $error("pair irq without enable");
	c_wide_wrap: cover property (i_ce && wide && lo_tick && match32);
	c_pair_irq: cover property (o_pair_irq);
	c_capture_read: cover property (rd_first && cap_sel && !cap_con);
endmodule

// ### testbench/icwt_pin_model.sv
// partner model: external digital signals on the capture pins
module icwt_pin_model import icwt_pkg::*; (
	input  wire logic              i_core_clk,
	output logic      [CH_NUM-1:0] o_pins
);
	timeunit 1ns;
	timeprecision 1ns;
	initial o_pins = '0;
	// pins rest low; each level held well past the two-cycle minimum
	task pulse(input int ch, input int n);
		repeat (n) begin
			@(posedge i_core_clk);
			o_pins[ch] <= 1'h1;
			repeat (4) @(posedge i_core_clk);
			o_pins[ch] <= 1'h0;
			repeat (8) @(posedge i_core_clk);
		end
	endtask
endmodule

// ### testbench/tb.sv
// self-checking bench for the capture unit and its time base
module tb;
	import icwt_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {
		logic [IDX_W-1:0] idx;
		logic             wr;
		logic [15:0]      wd;
		logic [15:0]      ex;
	} icwt_row_type;
	localparam logic [IDX_W-1:0] BUF0 = IDX_CAPTURE_FIRST;
	localparam logic [IDX_W-1:0] CTL0 = IDX_CAPTURE_FIRST + 10'h002;
	logic              i_core_clk, i_rst, i_sleep, gate_pin;
	logic              i_psel, i_penable, i_pwrite;
	logic [ADDR_W-1:0] i_paddr;
	logic [31:0]       i_pwdata, o_prdata;
	logic              o_pready, o_pslverr, o_pair_irq, err;
	logic [CH_NUM-1:0] i_capture_pin, o_capture_irq;
	logic [15:0]       rdv;
	int                fail_count, n_tests;
	int                pn[6], nc[6];
	icwt_row_type      rows[10];

	icwt_top uut (
		.i_core_clk     (i_core_clk),
		.i_rst          (i_rst),
		.i_ce           (1'h1),
		.i_sleep        (i_sleep),
		.i_idle         (1'h0),
		.i_psel         (i_psel),
		.i_penable      (i_penable),
		.i_pwrite       (i_pwrite),
		.i_paddr        (i_paddr),
		.i_pwdata       (i_pwdata),
		.i_pstrb        (4'hF),
		.o_prdata       (o_prdata),
		.o_pready       (o_pready),
		.o_pslverr      (o_pslverr),
		.i_capture_pin  (i_capture_pin),
		.i_low_clk_pin  (gate_pin),
		.i_high_clk_pin (1'h0),
		.o_pair_irq     (o_pair_irq),
		.o_low_irq      (),
		.o_capture_irq  (o_capture_irq)
	);
	icwt_pin_model pm (.i_core_clk(i_core_clk), .o_pins(i_capture_pin));

	task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		n_tests++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
		end
	endtask
	// holds the request until pready is sampled high
	task apb(input logic [IDX_W-1:0] idx, input logic w,
		input logic [15:0] d);
		@(posedge i_core_clk);
		i_psel    <= 1'h1;
		i_pwrite  <= w;
		i_paddr   <= {idx, 2'h0};
		i_pwdata  <= {16'h0000, d};
		@(posedge i_core_clk);
		i_penable <= 1'h1;
		do
			@(posedge i_core_clk);
		while (o_pready !== 1'h1);
		rdv = o_prdata[15:0];
		err = o_pslverr;
		i_psel    <= 1'h0;
		i_penable <= 1'h0;
	endtask
	task wr(input logic [IDX_W-1:0] idx, input logic [15:0] d);
		apb(idx, 1'h1, d);
	endtask
	task rd(input string nm, input logic [IDX_W-1:0] idx,
		input logic [15:0] e);
		apb(idx, 1'h0, 16'h0000);
		chk(nm, rdv, e);
	endtask
	task stop_test();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		i_core_clk = 1'h0;
		forever #50 i_core_clk = ~i_core_clk;
	end
	initial begin
		repeat (20000) @(posedge i_core_clk);
		fail_count++;
		stop_test();
	end

	initial begin
		i_rst = 1'h1;
		i_sleep = 1'h0;
		gate_pin = 1'h0;
		i_psel = 1'h0;
		i_penable = 1'h0;
		i_pwrite = 1'h0;
		i_paddr = '0;
		i_pwdata = '0;
		pn = '{0, 1, 1, 1, 4, 16};
		nc = '{0, 2, 1, 1, 1, 1};
		rows = '{'{IDX_PERIOD_LOW_WORD, 1'h0, 16'h0, 16'hFFFF},
			'{IDX_PERIOD_HIGH_WORD, 1'h0, 16'h0, 16'hFFFF},
			'{IDX_LOW_TIMER_CONTROL, 1'h0, 16'h0, 16'h0000},
			'{CTL0, 1'h0, 16'h0, 16'h0000},
			'{IDX_INT_FLAG_ZERO, 1'h0, 16'h0, 16'h0000},
			'{IDX_PERIOD_LOW_WORD, 1'h1, 16'h1234, 16'h1234},
			'{IDX_HIGH_TIMER_CONTROL, 1'h1, 16'hFFFF, HIGH_CON_WMASK},
			'{IDX_HIGH_TIMER_CONTROL, 1'h1, 16'h0, 16'h0000},
			'{CTL0, 1'h1, 16'h0018, 16'h0000},
			'{10'h000, 1'h0, 16'h0, 16'h0000}};
		repeat (16) @(posedge i_core_clk);
		i_rst <= 1'h0;
		for (int i = 0; i < 10; i++) begin
			if (rows[i].wr)
				wr(rows[i].idx, rows[i].wd);
			rd("register", rows[i].idx, rows[i].ex);
		end
		chk("unmapped error", {15'h0, err}, 16'h0001);
		$display("test registers done");
		wr(IDX_PERIOD_LOW_WORD, 16'h0005);
		wr(IDX_PERIOD_HIGH_WORD, 16'h0000);
		wr(IDX_TIMER_LOW_COUNT, 16'h0000);
		wr(IDX_TIMER_HIGH_COUNT, 16'h0000);
		i_sleep <= 1'h1;
		wr(IDX_LOW_TIMER_CONTROL, 16'h8008);
		repeat (20) @(posedge i_core_clk);
		rd("sleep count", IDX_TIMER_LOW_COUNT, 16'h0000);
		rd("sleep flag", IDX_INT_FLAG_ZERO, 16'h0000);
		i_sleep <= 1'h0;
		repeat (30) @(posedge i_core_clk);
		chk("irq masked", {15'h0, o_pair_irq}, 16'h0000);
		wr(IDX_LOW_TIMER_CONTROL, 16'h0008);
		rd("wide wrap", IDX_TIMER_HIGH_COUNT, 16'h0000);
		apb(IDX_TIMER_LOW_COUNT, 1'h0, 16'h0000);
		chk("wrap bound", {15'h0, rdv > 16'h0005}, 16'h0000);
		rd("pair flag", IDX_INT_FLAG_ZERO, 16'h0080);
		wr(IDX_INT_ENABLE_ZERO, 16'h0180);
		@(negedge i_core_clk);
		chk("irq on", {15'h0, o_pair_irq}, 16'h0001);
		wr(IDX_INT_FLAG_ZERO, 16'h0000);
		@(negedge i_core_clk);
		chk("irq cleared", {15'h0, o_pair_irq}, 16'h0000);
		wr(IDX_TIMER_HIGH_HOLDING, 16'h00AB);
		wr(IDX_TIMER_LOW_COUNT, 16'h0002);
		rd("hold load", IDX_TIMER_HIGH_COUNT, 16'h00AB);
		wr(IDX_TIMER_HIGH_HOLDING, 16'h0011);
		rd("low word", IDX_TIMER_LOW_COUNT, 16'h0002);
		rd("hold latch", IDX_TIMER_HIGH_HOLDING, 16'h00AB);
		wr(IDX_LOW_TIMER_CONTROL, 16'h8048);
		gate_pin <= 1'h1;
		repeat (6) @(posedge i_core_clk);
		gate_pin <= 1'h0;
		repeat (6) @(posedge i_core_clk);
		rd("gate fall", IDX_INT_FLAG_ZERO, 16'h0080);
		wr(IDX_INT_FLAG_ZERO, 16'h0000);
		wr(IDX_LOW_TIMER_CONTROL, 16'h0000);
		$display("test timer done");
		wr(CTL0, 16'h0083);
		for (int i = 1; i < 6; i++) begin
			wr(IDX_TIMER_LOW_COUNT, 16'(i));
			pm.pulse(0, 1);
		end
		rd("overflow", CTL0, 16'h009B);
		rd("capture flag", IDX_INT_FLAG_ZERO, 16'h0100);
		chk("capture irq", {8'h00, o_capture_irq}, 16'h0001);
		for (int i = 1; i < 4; i++)
			rd("fifo order", BUF0, 16'(i));
		wr(IDX_TIMER_LOW_COUNT, 16'h0006);
		pm.pulse(0, 1);
		rd("fifth lost", BUF0, 16'h0004);
		rd("drained", CTL0, 16'h0083);
		wr(IDX_TIMER_HIGH_COUNT, 16'h0055);
		wr(CTL0, 16'h0003);
		pm.pulse(0, 1);
		rd("high base", BUF0, 16'h0055);
		for (int m = 1; m < 6; m++) begin
			wr(CTL0, 16'h0080);
			wr(CTL0, 16'h0080 | 16'(m));
			wr(IDX_TIMER_LOW_COUNT, 16'(m));
			pm.pulse(0, pn[m]);
			for (int j = 0; j < nc[m]; j++)
				rd("mode stamp", BUF0, 16'(m));
			rd("mode empty", CTL0, 16'h0080 | 16'(m));
		end
		wr(IDX_INT_FLAG_ZERO, 16'h0000);
		wr(CTL0, 16'h0087);
		pm.pulse(0, 1);
		rd("flag only", CTL0, 16'h0087);
		rd("flag only irq", IDX_INT_FLAG_ZERO, 16'h0100);
		wr(CTL0, 16'h0086);
		pm.pulse(0, 1);
		rd("reserved off", CTL0, 16'h0086);
		wr(CTL0, 16'h0084);
		pm.pulse(0, 3);
		wr(CTL0, 16'h0080);
		wr(CTL0, 16'h0084);
		pm.pulse(0, 3);
		rd("off clears", CTL0, 16'h0084);
		pm.pulse(0, 1);
		rd("fourth edge", CTL0, 16'h008C);
		$display("test capture done");
		pm.pulse(0, 2);
		i_rst <= 1'h1;
		repeat (2) @(posedge i_core_clk);
		i_rst <= 1'h0;
		rd("reset period", IDX_PERIOD_LOW_WORD, 16'hFFFF);
		wr(CTL0, 16'h0084);
		pm.pulse(0, 3);
		rd("reset prescale", CTL0, 16'h0084);
		pm.pulse(0, 1);
		rd("reset fourth", CTL0, 16'h008C);
		$display("test reset done");
		stop_test();
	end
endmodule
